//--- rtl/dodict_bank.sv
// Purpose: object dictionary of a servo drive, index/subindex access
// Assumes: requests are single-cycle strobes; flash image presented on nv_* ports
// Notes:   answer comes one cycle after a strobe taken while ready_out is high
//
// Contract
// [RULE1] simple variable uses subindex zero only
// [RULE2] array element selected by subindex one up
// [RULE3] record member selected by subindex one up
// [RULE4] subindex zero of array/record reads count
// [RULE5] signed two's complement, unsigned plain binary
// [RULE6] float32: sign, 8-bit exponent, 23-bit mantissa
// [RULE7] constants never change during operation
// [RULE8] non-machine data load defaults after switch-on
// [RULE9] machine data restored from flash at switch-on
// [RULE10] controller converts raw values by unit step
// [RULE11] sensor resolution steps equal one revolution
// [RULE12] position unit scaled to sensor steps by ratio
// [RULE13] speed machine data in quarter/half/whole rpm
// [RULE14] velocity numerator given in half/quarter rpm
// [RULE15] select variables accept only enumerated codes
// [RULE16] bad access rejected, storage left unchanged
`include "dodict_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dodict_bank #(
  parameter int NV_W = 3
) (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        nv_valid_in,
  input  wire logic [NV_W-1:0] nv_addr_in,
  input  wire logic [31:0] nv_data_in,
  input  wire logic        nv_done_in,
  input  wire logic        req_in,
  input  wire logic        req_write_in,
  input  wire logic [15:0] req_index_in,
  input  wire logic [7:0]  req_subindex_in,
  input  wire logic [31:0] req_wdata_in,
  output logic             ready_out,
  output logic             ack_out,
  output logic [1:0]       err_out,
  output logic [31:0]      rdata_out,
  output logic [31:0]      posfac_num_out,
  output logic [31:0]      posfac_den_out,
  output logic [31:0]      sensres_out,
  output logic [31:0]      velfac_num_out,
  output logic [31:0]      velfac_den_out,
  output logic [31:0]      maxspd_out,
  output logic [15:0]      opmode_out,
  output logic             cmd_trig_out,
  input  wire logic [15:0] status_in,
  input  wire logic [7:0]  temp_in
);
  dodict_pkg::dodict_state_t state;
  logic [31:0] nv [0:`DOD_NV_COUNT-1];
  logic [15:0] opmode;
  logic [15:0] ctrl;
  logic [31:0] gain;
  logic [31:0] pos_num;
  logic [31:0] pos_den;
  logic [31:0] rec_a;
  logic [15:0] rec_b;
  logic        hit;
  logic        acc_ok;
  logic        val_ok;
  logic [31:0] rd;
  dodict_pkg::dodict_access_t acc;
  dodict_pkg::dodict_err_t    next_err;
  // sign extension keeps i8/i16 two's complement in a 32-bit word
  function automatic logic [31:0] dod_extend(input logic [31:0] v,
                                             input dodict_pkg::dodict_dtype_t t);
    case (t)
      dodict_pkg::DOD_T_I8:  dod_extend = {{24{v[7]}}, v[7:0]};
      dodict_pkg::DOD_T_I16: dod_extend = {{16{v[15]}}, v[15:0]};
      dodict_pkg::DOD_T_U8:  dod_extend = {24'h000000, v[7:0]};
      dodict_pkg::DOD_T_U16: dod_extend = {16'h0000, v[15:0]};
      default:               dod_extend = v;
    endcase
  endfunction
  assign ready_out = (state == dodict_pkg::DOD_S_RUN);
  // decode: object kind, subindex legality, access and read value
  always_comb
  begin
    hit = 1'b1;
    acc = dodict_pkg::DOD_ACC_RW;
    rd  = 32'h00000000;
    val_ok = 1'b1;
    case (req_index_in)
      `DOD_IDX_OPMODE:
      begin
        hit = (req_subindex_in == 8'h00); // [RULE1]
        rd  = dod_extend({16'h0000, opmode}, dodict_pkg::DOD_T_I16); // [RULE5]
        val_ok = (req_wdata_in[15:0] >= 16'h0001) && (req_wdata_in[15:0] <= 16'h0003); // [RULE15]
      end
      `DOD_IDX_CTRL:
      begin
        hit = (req_subindex_in == 8'h00); // [RULE1]
        rd  = {16'h0000, ctrl};
      end
      `DOD_IDX_STATUS:
      begin
        hit = (req_subindex_in == 8'h00);
        acc = dodict_pkg::DOD_ACC_RO;
        rd  = {16'h0000, status_in};
      end
      `DOD_IDX_TEMP:
      begin
        // raw value in 0.1 degree steps, caller scales it
        hit = (req_subindex_in == 8'h00); // [RULE10]
        acc = dodict_pkg::DOD_ACC_RO;
        rd  = dod_extend({24'h000000, temp_in}, dodict_pkg::DOD_T_I8); // [RULE5]
      end
      `DOD_IDX_VERSION:
      begin
        hit = (req_subindex_in == 8'h00);
        acc = dodict_pkg::DOD_ACC_RO;
        rd  = `DOD_CONST_VERSION; // [RULE7]
      end
      `DOD_IDX_CMDTRIG:
      begin
        hit = (req_subindex_in == 8'h00);
        acc = dodict_pkg::DOD_ACC_WO;
      end
      `DOD_IDX_GAIN:
      begin
        hit = (req_subindex_in == 8'h00);
        rd  = gain; // [RULE6]
      end
      `DOD_IDX_SENSRES:
      begin
        hit = (req_subindex_in == 8'h00);
        rd  = nv[`DOD_NV_SENSRES]; // [RULE11]
      end
      `DOD_IDX_MAXSPD:
      begin
        hit = (req_subindex_in == 8'h00);
        rd  = nv[`DOD_NV_MAXSPD]; // [RULE13]
      end
      `DOD_IDX_POSLIM, `DOD_IDX_POSFAC, `DOD_IDX_VELFAC:
      begin
        hit = (req_subindex_in <= 8'h02); // [RULE2]
        if (req_subindex_in == 8'h00)
        begin
          acc = dodict_pkg::DOD_ACC_RO;
          rd  = 32'h00000002; // [RULE4]
        end
        else if (req_index_in == `DOD_IDX_POSLIM)
          rd = (req_subindex_in == 8'h01) ? nv[`DOD_NV_POSLIM_MIN] : nv[`DOD_NV_POSLIM_MAX];
        else if (req_index_in == `DOD_IDX_POSFAC)
          rd = (req_subindex_in == 8'h01) ? pos_num : pos_den; // [RULE12]
        else
          rd = (req_subindex_in == 8'h01) ? nv[`DOD_NV_VELFAC_NUM] : nv[`DOD_NV_VELFAC_DEN];
        if (req_index_in != `DOD_IDX_POSLIM && req_subindex_in != 8'h00)
          val_ok = (req_wdata_in != 32'h00000000);
      end
      `DOD_IDX_REC:
      begin
        hit = (req_subindex_in <= 8'h02); // [RULE3]
        if (req_subindex_in == 8'h00)
        begin
          acc = dodict_pkg::DOD_ACC_RO;
          rd  = 32'h00000002; // [RULE4]
        end
        else if (req_subindex_in == 8'h01)
          rd = rec_a;
        else
          rd = dod_extend({16'h0000, rec_b}, dodict_pkg::DOD_T_U16); // [RULE5]
      end
      default:
        hit = 1'b0;
    endcase
    acc_ok = req_write_in ? (acc != dodict_pkg::DOD_ACC_RO) : (acc != dodict_pkg::DOD_ACC_WO);
    if (!hit)
      next_err = dodict_pkg::DOD_E_NOOBJ;
    else if (!acc_ok)
      next_err = dodict_pkg::DOD_E_ACCESS;
    else if (req_write_in && !val_ok)
      next_err = dodict_pkg::DOD_E_VALUE;
    else
      next_err = dodict_pkg::DOD_E_OK;
  end
  logic wr_ok;
  assign wr_ok = req_in && ready_out && req_write_in && (next_err == dodict_pkg::DOD_E_OK);
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      state <= dodict_pkg::DOD_S_LOAD;
    else if (state == dodict_pkg::DOD_S_LOAD && nv_done_in)
      state <= dodict_pkg::DOD_S_RUN; // [RULE9]
  end
  // machine data: filled from flash while loading, editable afterwards
  always_ff @(posedge mclk_in)
  begin
    if (state == dodict_pkg::DOD_S_LOAD && nv_valid_in && nv_addr_in < NV_W'(`DOD_NV_COUNT))
      nv[nv_addr_in] <= nv_data_in; // [RULE9]
    else if (wr_ok) // [RULE16]
    begin
      case (req_index_in)
        `DOD_IDX_SENSRES: nv[`DOD_NV_SENSRES] <= req_wdata_in;
        `DOD_IDX_MAXSPD:  nv[`DOD_NV_MAXSPD] <= req_wdata_in; // [RULE13]
        `DOD_IDX_POSLIM:
          nv[(req_subindex_in == 8'h01) ? `DOD_NV_POSLIM_MIN : `DOD_NV_POSLIM_MAX] <= req_wdata_in;
        `DOD_IDX_VELFAC:
          nv[(req_subindex_in == 8'h01) ? `DOD_NV_VELFAC_NUM : `DOD_NV_VELFAC_DEN] <= req_wdata_in; // [RULE14]
        default: ;
      endcase
    end
  end
  // parameters: documented defaults at switch-on
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      opmode  <= 16'(`DOD_RST_OPMODE); // [RULE8]
      ctrl    <= 16'(`DOD_RST_CTRL);
      gain    <= `DOD_RST_GAIN;
      pos_num <= `DOD_RST_FAC_NUM; // [RULE12]
      pos_den <= `DOD_RST_FAC_DEN;
      rec_a   <= `DOD_RST_REC_A;
      rec_b   <= 16'(`DOD_RST_REC_B);
    end
    else if (wr_ok) // [RULE16]
    begin
      case (req_index_in)
        `DOD_IDX_OPMODE: opmode <= req_wdata_in[15:0]; // [RULE15]
        `DOD_IDX_CTRL:   ctrl <= req_wdata_in[15:0];
        `DOD_IDX_GAIN:   gain <= req_wdata_in;
        `DOD_IDX_POSFAC:
          if (req_subindex_in == 8'h01)
            pos_num <= req_wdata_in;
          else
            pos_den <= req_wdata_in;
        `DOD_IDX_REC:
          if (req_subindex_in == 8'h01)
            rec_a <= req_wdata_in;
          else
            rec_b <= req_wdata_in[15:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ack_out      <= 1'b0;
      err_out      <= 2'h0;
      rdata_out    <= 32'h00000000;
      cmd_trig_out <= 1'b0;
    end
    else
    begin
      ack_out      <= req_in && ready_out;
      err_out      <= (req_in && ready_out) ? next_err : 2'h0;
      // refused reads return zero so stale data never leaks
      rdata_out    <= (req_in && ready_out && !req_write_in && next_err == dodict_pkg::DOD_E_OK) ? rd : 32'h00000000;
      cmd_trig_out <= wr_ok && (req_index_in == `DOD_IDX_CMDTRIG);
    end
  end
  assign posfac_num_out = pos_num;
  assign posfac_den_out = pos_den;
  assign sensres_out    = nv[`DOD_NV_SENSRES];
  assign velfac_num_out = nv[`DOD_NV_VELFAC_NUM];
  assign velfac_den_out = nv[`DOD_NV_VELFAC_DEN];
  assign maxspd_out     = nv[`DOD_NV_MAXSPD];
  assign opmode_out     = opmode;
  AST_CONST_READ: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE7]
    req_in && ready_out && !req_write_in && req_index_in == `DOD_IDX_VERSION && req_subindex_in == 8'h00
    |=> rdata_out == `DOD_CONST_VERSION) else $error("constant read wrong");
  AST_COUNT_READ: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE4]
    req_in && ready_out && !req_write_in && req_index_in == `DOD_IDX_POSLIM && req_subindex_in == 8'h00
    |=> ack_out && err_out == 2'h0 && rdata_out == 32'h00000002) else $error("count read wrong");
  AST_SIMPLE_SUB: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE1]
    req_in && ready_out && req_index_in == `DOD_IDX_CTRL && req_subindex_in != 8'h00
    |=> err_out == 2'h1) else $error("simple subindex not refused");
  AST_RO_WRITE: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE16]
    req_in && ready_out && req_write_in && req_index_in == `DOD_IDX_STATUS
    |=> err_out == 2'h2) else $error("read-only write not refused");
  AST_SELECT: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE15]
    req_in && ready_out && req_write_in && req_index_in == `DOD_IDX_OPMODE && req_subindex_in == 8'h00
    && req_wdata_in[15:0] > 16'h0003 |=> $stable(opmode)) else $error("bad select code stored");
  AST_DEFAULTS: assert property (@(posedge mclk_in) // [RULE8]
    !nrst_in |=> opmode == 16'h0001 && pos_num == 32'h00000001 && !ack_out) else $error("default missing");
  AST_LOAD_QUIET: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE9]
    !ready_out |=> !ack_out && !cmd_trig_out) else $error("access during load");
  AST_POSFAC_WR: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE12]
    wr_ok && req_index_in == `DOD_IDX_POSFAC && req_subindex_in == 8'h01
    |=> posfac_num_out == $past(req_wdata_in)) else $error("position factor not stored");
  AST_TRIG: assert property (@(posedge mclk_in) disable iff (!nrst_in) // [RULE16]
    cmd_trig_out |-> $past(req_in && ready_out && req_write_in && req_subindex_in == 8'h00
    && req_index_in == `DOD_IDX_CMDTRIG)) else $error("trigger without write");
  COV_ARRAY_RD: cover property (@(posedge mclk_in) ack_out && err_out == 2'h0 && $past(req_index_in) == `DOD_IDX_POSLIM);
  COV_REC_WR: cover property (@(posedge mclk_in) wr_ok && req_index_in == `DOD_IDX_REC);
  COV_ERR: cover property (@(posedge mclk_in) ack_out && err_out == 2'h1);
endmodule
`default_nettype wire

//--- rtl/dodict_consts.svh
// Purpose: constants for the drive object dictionary
// Assumes: one clock, synchronous reset
// Notes:   indices and defaults are illustrative
`ifndef DODICT_CONSTS_SVH
`define DODICT_CONSTS_SVH
`define DOD_IDX_OPMODE      16'h5f42
`define DOD_IDX_CTRL        16'h6040
`define DOD_IDX_STATUS      16'h6041
`define DOD_IDX_POSLIM      16'h607d
`define DOD_IDX_POSFAC      16'h6093
`define DOD_IDX_VELFAC      16'h6094
`define DOD_IDX_SENSRES     16'h6410
`define DOD_IDX_MAXSPD      16'h6420
`define DOD_IDX_CMDTRIG     16'h6430
`define DOD_IDX_VERSION     16'h6500
`define DOD_IDX_TEMP        16'h6510
`define DOD_IDX_GAIN        16'h6520
`define DOD_IDX_REC         16'h6530
`define DOD_RST_OPMODE      32'h00000001
`define DOD_RST_CTRL        32'h00000000
`define DOD_RST_GAIN        32'h3f800000
`define DOD_RST_FAC_NUM     32'h00000001
`define DOD_RST_FAC_DEN     32'h00000001
`define DOD_RST_REC_A       32'h00000000
`define DOD_RST_REC_B       32'h00000000
`define DOD_RST_CMDTRIG     32'h00000000
`define DOD_CONST_VERSION   32'h00000123
`define DOD_NV_COUNT        6
`define DOD_NV_SENSRES      3'h0
`define DOD_NV_POSLIM_MIN   3'h1
`define DOD_NV_POSLIM_MAX   3'h2
`define DOD_NV_VELFAC_NUM   3'h3
`define DOD_NV_VELFAC_DEN   3'h4
`define DOD_NV_MAXSPD       3'h5
`define DOD_F32_SIGN        31
`define DOD_F32_EXP_HI      30
`define DOD_F32_EXP_LO      23
`define DOD_F32_MAN_HI      22
`endif

//--- rtl/dodict_pkg.sv
// Purpose: types for the drive object dictionary
// Assumes: nothing
// Notes:   constants live in dodict_consts.svh
package dodict_pkg;
  typedef enum logic [2:0] {
    DOD_T_I8, DOD_T_I16, DOD_T_I32, DOD_T_U8, DOD_T_U16, DOD_T_U32, DOD_T_F32
  } dodict_dtype_t;
  typedef enum logic [1:0] {
    DOD_ACC_RW, DOD_ACC_RO, DOD_ACC_WO
  } dodict_access_t;
  typedef enum logic [1:0] {
    DOD_E_OK, DOD_E_NOOBJ, DOD_E_ACCESS, DOD_E_VALUE
  } dodict_err_t;
  typedef enum {
    DOD_S_LOAD, DOD_S_RUN
  } dodict_state_t;
endpackage

//--- testbench/dodict_ctrl_model.sv
// Purpose: controller-side model issuing index/subindex accesses
// Assumes: one access at a time; answer read 1 ns after the edge that takes the request
// Notes:   released request lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module dodict_ctrl_model (
  input  wire logic        mclk_in,
  input  wire logic        ready_in,
  input  wire logic        ack_in,
  input  wire logic [1:0]  err_in,
  input  wire logic [31:0] rdata_in,
  output logic             req_out,
  output logic             req_write_out,
  output logic [15:0]      req_index_out,
  output logic [7:0]       req_subindex_out,
  output logic [31:0]      req_wdata_out
);
  initial
  begin
    req_out          = 1'b0;
    req_write_out    = 1'b0;
    req_index_out    = 16'h0000;
    req_subindex_out = 8'h00;
    req_wdata_out    = 32'h00000000;
  end

  // callers give sub 0 on simple objects, 1 up on members, except where a refusal is meant
  // values go as raw unit steps, velocity numerators in half/quarter rpm
  // only enumerated select codes unless a refusal is meant
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, input bit need_ready, output logic got,
                        output logic [1:0] e, output logic [31:0] rd, output bit hung);
    int n;
    n    = 0;
    hung = 1'b0;
    @(posedge mclk_in);
    // bounded wait: a stuck load phase must not hang the run
    while (need_ready && ready_in !== 1'b1 && n < 400)
    begin
      @(posedge mclk_in);
      n++;
    end
    hung             = (n >= 400);
    req_out          <= 1'b1;
    req_write_out    <= wr;
    req_index_out    <= idx;
    req_subindex_out <= sub;
    req_wdata_out    <= wd;
    @(posedge mclk_in);
    req_out          <= 1'b0;
    req_write_out    <= ~wr;
    req_index_out    <= ~idx;
    req_subindex_out <= ~sub;
    req_wdata_out    <= ~wd;
    #1;
    got = ack_in;
    e   = err_in;
    rd  = rdata_in;
  endtask
endmodule
`default_nettype wire

//--- testbench/drive_object_dictionary_access_bench.sv
// Purpose: self-checking bench for the object dictionary bank
// Assumes: flash image fed on nv_* after the first reset only
// Notes:   rows hold the plain accesses and refusals; reset precedes them by hand, trigger and mid-run reset follow
`timescale 1ns/1ps
`default_nettype none
`include "dodict_consts.svh"
module drive_object_dictionary_access_bench;
  typedef struct packed {logic wr; logic [15:0] idx; logic [7:0] sub; logic [31:0] wd;
                         logic [1:0] er; logic [31:0] rd;} dodict_row_t;
  logic        mclk_in, nrst_in, nv_valid_in, nv_done_in, req_in, req_write_in;
  logic        ready_out, ack_out, cmd_trig_out, got;
  logic [2:0]  nv_addr_in;
  logic [1:0]  err_out, e;
  logic [7:0]  req_subindex_in, temp_in;
  logic [15:0] req_index_in, status_in, opmode_out;
  logic [31:0] nv_data_in, req_wdata_in, rdata_out, rd, posfac_num_out, posfac_den_out;
  logic [31:0] sensres_out, velfac_num_out, velfac_den_out, maxspd_out;
  bit          hung;
  int          num_errors, checks_done;
  logic [31:0] flash_img [6] = '{32'h00001000, 32'he0000000, 32'h1fffffff,
                                 32'h00000002, 32'h00000001, 32'h00001770};
  dodict_row_t rows [41] = '{
    '{1'b0, 16'h6410, 8'h00, 32'h0, 2'h0, 32'h00001000},
    '{1'b0, 16'h607d, 8'h00, 32'h0, 2'h0, 32'h00000002},
    '{1'b0, 16'h607d, 8'h01, 32'h0, 2'h0, 32'he0000000},
    '{1'b0, 16'h607d, 8'h02, 32'h0, 2'h0, 32'h1fffffff},
    '{1'b0, 16'h607d, 8'h03, 32'h0, 2'h1, 32'h00000000},
    '{1'b0, 16'h6093, 8'h01, 32'h0, 2'h0, 32'h00000001},
    '{1'b0, 16'h6093, 8'h02, 32'h0, 2'h0, 32'h00000001},
    '{1'b0, 16'h6094, 8'h01, 32'h0, 2'h0, 32'h00000002},
    '{1'b0, 16'h6094, 8'h02, 32'h0, 2'h0, 32'h00000001},
    '{1'b0, 16'h6420, 8'h00, 32'h0, 2'h0, 32'h00001770},
    '{1'b0, 16'h6500, 8'h00, 32'h0, 2'h0, `DOD_CONST_VERSION},
    '{1'b1, 16'h6500, 8'h00, 32'h5, 2'h2, 32'h00000000},
    '{1'b0, 16'h6500, 8'h00, 32'h0, 2'h0, `DOD_CONST_VERSION},
    '{1'b0, 16'h6520, 8'h00, 32'h0, 2'h0, `DOD_RST_GAIN},
    '{1'b0, 16'h5f42, 8'h00, 32'h0, 2'h0, `DOD_RST_OPMODE},
    '{1'b1, 16'h5f42, 8'h00, 32'h2, 2'h0, 32'h00000000},
    '{1'b0, 16'h5f42, 8'h00, 32'h0, 2'h0, 32'h00000002},
    '{1'b1, 16'h5f42, 8'h00, 32'h4, 2'h3, 32'h00000000},
    '{1'b1, 16'h5f42, 8'h00, 32'h0, 2'h3, 32'h00000000},
    '{1'b1, 16'h5f42, 8'h00, 32'h3, 2'h0, 32'h00000000},
    '{1'b0, 16'h5f42, 8'h00, 32'h0, 2'h0, 32'h00000003},
    '{1'b0, 16'h6410, 8'h01, 32'h0, 2'h1, 32'h00000000},
    '{1'b0, 16'h1234, 8'h00, 32'h0, 2'h1, 32'h00000000},
    '{1'b0, 16'h6430, 8'h00, 32'h0, 2'h2, 32'h00000000},
    '{1'b1, 16'h6094, 8'h01, 32'h0, 2'h3, 32'h00000000},
    '{1'b1, 16'h6094, 8'h01, 32'h4, 2'h0, 32'h00000000},
    '{1'b0, 16'h6094, 8'h01, 32'h0, 2'h0, 32'h00000004},
    '{1'b1, 16'h607d, 8'h00, 32'h3, 2'h2, 32'h00000000},
    '{1'b0, 16'h6530, 8'h00, 32'h0, 2'h0, 32'h00000002},
    '{1'b1, 16'h6530, 8'h02, 32'hbeef, 2'h0, 32'h00000000},
    '{1'b0, 16'h6530, 8'h02, 32'h0, 2'h0, 32'h0000beef},
    '{1'b0, 16'h6041, 8'h00, 32'h0, 2'h0, 32'h00008421},
    '{1'b0, 16'h6510, 8'h00, 32'h0, 2'h0, 32'hfffffff6},
    '{1'b0, 16'h6040, 8'h00, 32'h0, 2'h0, `DOD_RST_CTRL},
    '{1'b1, 16'h6040, 8'h00, 32'h55, 2'h0, 32'h00000000},
    '{1'b1, 16'h6093, 8'h02, 32'h7, 2'h0, 32'h00000000},
    '{1'b0, 16'h6093, 8'h02, 32'h0, 2'h0, 32'h00000007},
    '{1'b1, 16'h6093, 8'h01, 32'h3, 2'h0, 32'h00000000},
    '{1'b0, 16'h6093, 8'h01, 32'h0, 2'h0, 32'h00000003},
    '{1'b0, 16'h6040, 8'h01, 32'h0, 2'h1, 32'h00000000},
    '{1'b1, 16'h6041, 8'h00, 32'h1, 2'h2, 32'h00000000}};

  dodict_bank dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .nv_valid_in(nv_valid_in),
    .nv_addr_in(nv_addr_in), .nv_data_in(nv_data_in), .nv_done_in(nv_done_in),
    .req_in(req_in), .req_write_in(req_write_in), .req_index_in(req_index_in),
    .req_subindex_in(req_subindex_in), .req_wdata_in(req_wdata_in), .ready_out(ready_out),
    .ack_out(ack_out), .err_out(err_out), .rdata_out(rdata_out),
    .posfac_num_out(posfac_num_out), .posfac_den_out(posfac_den_out),
    .sensres_out(sensres_out), .velfac_num_out(velfac_num_out),
    .velfac_den_out(velfac_den_out), .maxspd_out(maxspd_out), .opmode_out(opmode_out),
    .cmd_trig_out(cmd_trig_out), .status_in(status_in), .temp_in(temp_in));

  dodict_ctrl_model ctl (.mclk_in(mclk_in), .ready_in(ready_out), .ack_in(ack_out),
    .err_in(err_out), .rdata_in(rdata_out), .req_out(req_in), .req_write_out(req_write_in),
    .req_index_out(req_index_in), .req_subindex_out(req_subindex_in),
    .req_wdata_out(req_wdata_in));

  initial
  begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  task automatic close_out();
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic go(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                    input logic [31:0] wd, input bit need_ready);
    ctl.access(wr, idx, sub, wd, need_ready, got, e, rd, hung);
    if (hung)
    begin
      num_errors++;
      close_out();
    end
  endtask

  // reset, then flash words; a second pass may skip the words to show they persist
  task automatic restart(input bit with_words);
    nrst_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    nrst_in <= 1'b1;
    check({31'h0, ready_out}, 32'h0);
    go(1'b1, 16'h5f42, 8'h00, 32'h2, 1'b0);
    check({31'h0, got}, 32'h0);
    for (int i = 0; i < 6 && with_words; i++)
    begin
      @(posedge mclk_in);
      nv_valid_in <= 1'b1;
      nv_addr_in  <= i[2:0];
      nv_data_in  <= flash_img[i];
    end
    @(posedge mclk_in);
    nv_valid_in <= 1'b0;
    nv_data_in  <= ~nv_data_in;
    nv_done_in  <= 1'b1;
    @(posedge mclk_in);
    nv_done_in  <= 1'b0;
  endtask

  initial
  begin
    num_errors  = 0;
    checks_done = 0;
    nrst_in     = 1'b0;
    nv_valid_in = 1'b0;
    nv_done_in  = 1'b0;
    nv_addr_in  = 3'h0;
    nv_data_in  = 32'h00000000;
    status_in   = 16'h8421;
    temp_in     = 8'hf6;
    restart(1'b1);
    foreach (rows[i])
    begin
      go(rows[i].wr, rows[i].idx, rows[i].sub, rows[i].wd, 1'b1);
      check({31'h0, got}, 32'h1);
      check({30'h0, e}, {30'h0, rows[i].er});
      check(rd, rows[i].rd);
    end
    check(sensres_out, 32'h00001000);
    check(maxspd_out, 32'h00001770);
    check(velfac_num_out, 32'h00000004);
    check(posfac_den_out, 32'h00000007);
    check({16'h0, opmode_out}, 32'h00000003);
    check(posfac_num_out, 32'h00000003);
    check(velfac_den_out, 32'h00000001);
    go(1'b1, 16'h6430, 8'h00, 32'h1, 1'b1);
    check({31'h0, cmd_trig_out}, 32'h1);
    // mid-run reset with no flash words: machine data must survive
    @(posedge mclk_in);
    restart(1'b0);
    go(1'b0, 16'h5f42, 8'h00, 32'h0, 1'b1);
    check(rd, `DOD_RST_OPMODE);
    go(1'b0, 16'h6040, 8'h00, 32'h0, 1'b1);
    check(rd, `DOD_RST_CTRL);
    go(1'b0, 16'h6094, 8'h01, 32'h0, 1'b1);
    check(rd, 32'h00000004);
    check(maxspd_out, 32'h00001770);
    close_out();
  end
endmodule
`default_nettype wire
